/* include/lms_pkg.sv */
/*
  Constants, field layouts and operation codes shared by the long-mode
  system structure checker and its interrupt priority gate.
  Assumes one core clock and that every request arrives on that clock.
*/
package lms_pkg;
  // task priority
  localparam int         TPR_W      = 4;
  localparam logic [3:0] TPR_RST    = 4'h0;
  localparam logic [3:0] PRIO_MIN   = 4'h1;
  // table entry, gate and pseudo-descriptor sizes in bytes
  localparam logic [4:0] IDT_ENT_LNG = 5'h10;
  localparam logic [4:0] IDT_ENT_LEG = 5'h08;
  localparam logic [4:0] GATE_LNG    = 5'h10;
  localparam logic [4:0] GATE_LEG    = 5'h08;
  localparam logic [4:0] PSD_LNG     = 5'h0A;
  localparam logic [4:0] PSD_LEG     = 5'h06;
  localparam logic [4:0] SYS_ENT_LNG = 5'h10;
  localparam logic [4:0] SYS_ENT_LEG = 5'h08;
  // stack push widths and table base widths in bytes
  localparam logic [3:0] PUSH_LNG    = 4'h8;
  localparam logic [3:0] PUSH_LEG    = 4'h4;
  localparam logic [3:0] BASE_LNG    = 4'h8;
  localparam logic [3:0] BASE_LEG    = 4'h4;
  // descriptor index scaling as left shifts
  localparam int         IDX_SH_LNG  = 4;
  localparam int         IDX_SH_LEG  = 3;
  // system descriptor types
  localparam logic [3:0] TSS64_AVAIL = 4'h9;
  // task state segment byte offsets
  localparam logic [6:0] TSS_SP0     = 7'h04;
  localparam logic [6:0] TSS_IST1    = 7'h24;
  localparam logic [6:0] TSS_IOMAP   = 7'h66;
  localparam logic [6:0] TSS_STRIDE  = 7'h08;
  localparam logic [3:0] TSS_SEL_IST = 4'h3;
  localparam logic [3:0] TSS_SEL_IO  = 4'hA;
  // segment masks, bit order es cs ss ds fs gs
  localparam logic [5:0] SEG_ALL     = 6'h3F;
  localparam logic [5:0] SEG_BASE64  = 6'h0F;
  localparam logic [5:0] SEG_ATTR64  = 6'h39;
  localparam logic [5:0] SEG_NONE    = 6'h00;
  localparam logic [2:0] PAGE_LVL_LNG = 3'h4;
  localparam logic [2:0] PAGE_LVL_LEG = 3'h2;
  // operations presented by the core
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_TASK_SW  = 4'h1,
    OP_TASK_GT  = 4'h2,
    OP_CGATE16  = 4'h3,
    OP_CGATE32  = 4'h4,
    OP_LOAD_TR  = 4'h5,
    OP_LOAD_LDT = 4'h6,
    OP_LOAD_GDT = 4'h7,
    OP_LOAD_IDT = 4'h8,
    OP_ENT_REAL = 4'h9,
    OP_ENT_V86  = 4'hA,
    OP_INT_ENT  = 4'hB,
    OP_WR_TPR   = 4'hC,
    OP_RD_TPR   = 4'hD
  } lms_op_type;
endpackage : lms_pkg

/* include/lms_irq_if.sv */
/*
  Carrier between the checker and its interrupt priority gate.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/10ps
interface lms_irq_if;
  logic [3:0] task_priority_reg;
  logic       req;
  logic [3:0] cls;
  logic [7:0] vec;
  logic       deliver;
  logic [7:0] dvec;
  logic       pending;
  modport core (output task_priority_reg, req, cls, vec, input deliver, dvec, pending);
  modport gate (input task_priority_reg, req, cls, vec, output deliver, dvec, pending);
endinterface : lms_irq_if

/* src/lms_irq_gate.sv */
/*
  Holds one external interrupt and lets it out once its class beats the
  task priority. Assumes requests come from logic on the core clock.
*/
`timescale 1ns/10ps
module lms_irq_gate import lms_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the checker
  lms_irq_if.gate  gif
);
  logic       pend_q;
  logic [3:0] cls_q;
  logic [7:0] vec_q;
  logic       take;

  // -------------------------------------------------------------
  // priority compare
  // -------------------------------------------------------------
  // class 0 is not a class and is never taken
  assign take        = gif.req && (gif.cls >= PRIO_MIN) && (!pend_q || gif.deliver);
  // held while class is not above the priority
  assign gif.deliver = pend_q && (cls_q > gif.task_priority_reg);
  assign gif.dvec    = vec_q;
  assign gif.pending = pend_q;

  // capture wins over the clear of a delivered one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      cls_q  <= 4'h0;
      vec_q  <= 8'h00;
    end else if (take) begin
      pend_q <= 1'b1;
      cls_q  <= gif.cls;
      vec_q  <= gif.vec;
    end else if (gif.deliver) begin
      pend_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_gate_hold;
    @(posedge clk) disable iff (!rst_n)
      pend_q && (cls_q <= gif.task_priority_reg) |-> !gif.deliver ##1 pend_q;
  endproperty
  a_gate_hold : assert property (p_gate_hold) else $error("low class let out");
  property p_gate_class;
    @(posedge clk) disable iff (!rst_n)
      gif.deliver |-> cls_q >= PRIO_MIN;
  endproperty
  a_gate_class : assert property (p_gate_class) else $error("class 0 delivered");
endmodule : lms_irq_gate

/* src/lms_core.sv */
/*
  Long-mode system structure checker: task priority register, refusal of
  hardware task switching and task gates, and the long-mode sizes for
  descriptors, gates, stack pushes, paging and segment use.
  Assumes the decoder presents one operation per cycle on the core clock,
  and that mode inputs come from control registers on that clock.
*/
`timescale 1ns/10ps
module lms_core import lms_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // operating mode
  input  wire logic        long_active,
  input  wire logic        code64,
  input  wire logic        pae_en,
  // operation request
  input  wire logic        op_valid,
  input  wire lms_op_type  op_code,
  input  wire logic        op_rex,
  input  wire logic [3:0]  op_desc_type,
  input  wire logic [7:0]  op_vector,
  input  wire logic        op_pl_change,
  input  wire logic [3:0]  op_tss_sel,
  input  wire logic [63:0] op_wdata,
  // operation answer
  output logic             op_done,
  output logic             op_gp,
  output logic [63:0]      op_rdata,
  output logic [4:0]       op_mem_bytes,
  output logic [11:0]      op_idt_off,
  output logic [3:0]       op_push_bytes,
  output logic             op_push_ss,
  output logic             op_ss_null,
  output logic [3:0]       op_base_bytes,
  output logic [6:0]       op_tss_off,
  // external interrupts
  input  wire logic        ext_irq_req,
  input  wire logic [3:0]  ext_irq_class,
  input  wire logic [7:0]  ext_irq_vec,
  output logic             irq_deliver,
  output logic [7:0]       irq_vec,
  output logic             irq_pending,
  // mode status
  output logic [3:0]       tpr_value,
  output logic [2:0]       page_levels,
  output logic             va64,
  output logic             pae_fault,
  output logic [5:0]       seg_base_ign,
  output logic [5:0]       seg_lim_ign,
  output logic [5:0]       seg_attr_ign,
  output logic [5:0]       seg_pfx_ign
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // byte offset of a task state segment field
  function automatic logic [6:0] tss_field_off(input logic [3:0] sel);
    logic [6:0] idx;
    idx = {3'h0, sel};
    if (sel < TSS_SEL_IST)
      return 7'(TSS_SP0 + idx * TSS_STRIDE);
    else if (sel < TSS_SEL_IO)
      return 7'(TSS_IST1 + (idx - {3'h0, TSS_SEL_IST}) * TSS_STRIDE);
    else
      return TSS_IOMAP;
  endfunction : tss_field_off

  // pick the long-mode or legacy size
  function automatic logic [4:0] size_pick(input logic lng,
                                           input logic [4:0] a,
                                           input logic [4:0] b);
    return lng ? a : b;
  endfunction : size_pick

  // -------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------
  wire m64    = long_active && code64;
  wire lm     = long_active;
  wire is_tpr = (op_code == OP_WR_TPR) || (op_code == OP_RD_TPR);
  wire tpr_ok = m64 && op_rex;
  wire wr_bad = |op_wdata[63:TPR_W];
  wire is_int = (op_code == OP_INT_ENT);
  wire is_cg  = (op_code == OP_CGATE32);
  wire is_psd = (op_code == OP_LOAD_GDT) || (op_code == OP_LOAD_IDT);
  wire is_sys = (op_code == OP_LOAD_LDT) || (op_code == OP_LOAD_TR);

  // -------------------------------------------------------------
  // fault decode
  // -------------------------------------------------------------
  // compatibility mode is inside long mode, so lm covers it too
  wire gp_task = lm && (op_code == OP_TASK_SW);
  wire gp_gate = lm && (op_code == OP_TASK_GT);
  wire gp_cg16 = lm && (op_code == OP_CGATE16);
  wire gp_mode = lm && ((op_code == OP_ENT_REAL) || (op_code == OP_ENT_V86));
  // only a 64-bit tss, and only loaded from 64-bit code
  wire gp_ltr  = lm && (op_code == OP_LOAD_TR)
                 && (!code64 || (op_desc_type != TSS64_AVAIL));
  // reserved high bits must be zero on write
  wire gp_tpr  = is_tpr && (!tpr_ok || ((op_code == OP_WR_TPR) && wr_bad));
  wire gp_any  = gp_task || gp_gate || gp_cg16 || gp_mode || gp_ltr || gp_tpr;
  wire tpr_we  = op_valid && (op_code == OP_WR_TPR) && !gp_tpr;

  // -------------------------------------------------------------
  // size and frame decode
  // -------------------------------------------------------------
  // pseudo-descriptor and system entry sizes follow 64-bit code only
  wire [4:0] psd_sz  = size_pick(m64, PSD_LNG, PSD_LEG);
  wire [4:0] sys_sz  = size_pick(m64, SYS_ENT_LNG, SYS_ENT_LEG);
  wire [4:0] idt_sz  = size_pick(lm, IDT_ENT_LNG, IDT_ENT_LEG);
  wire [4:0] gate_sz = size_pick(lm, GATE_LNG, GATE_LEG);
  wire [4:0] mem_sz  = is_psd ? psd_sz :
                       is_sys ? sys_sz :
                       is_int ? idt_sz :
                       is_cg  ? gate_sz : 5'h00;
  // vector scaled by entry size
  wire [11:0] idx_lng = 12'({4'h0, op_vector} << IDX_SH_LNG);
  wire [11:0] idx_leg = 12'({4'h0, op_vector} << IDX_SH_LEG);
  wire [11:0] idt_off = !is_int ? 12'h000 : (lm ? idx_lng : idx_leg);
  wire        frame   = is_int || is_cg;
  wire [3:0]  push_sz = !frame ? 4'h0 : (lm ? PUSH_LNG : PUSH_LEG);
  // interrupts push the stack pointer always in long mode; gates, and legacy interrupts, only on a level change
  wire        push_ss = (is_int && lm) || (frame && op_pl_change);
  // in long mode a level change makes the new stack segment null, never read from the stack table
  wire        ss_null = lm && frame && op_pl_change;
  wire        ld_base = is_psd || is_sys;
  wire [3:0]  base_sz = !ld_base ? 4'h0 : (lm ? BASE_LNG : BASE_LEG);
  wire [6:0]  tss_off = tss_field_off(op_tss_sel);

  // -------------------------------------------------------------
  // answer registers
  // -------------------------------------------------------------
  logic        done_q;
  logic        gp_q;
  logic [63:0] rdata_q;
  logic [4:0]  mem_q;
  logic [11:0] idt_q;
  logic [3:0]  push_q;
  logic        pss_q;
  logic        ssn_q;
  logic [3:0]  base_q;
  logic [6:0]  tss_q;
  logic [3:0]  tpr_q;
  logic [3:0]  tpr_d;
  logic [63:0] rd_val;

  // read value is the held priority, upper bits zero
  assign rd_val = {{(64 - TPR_W){1'b0}}, tpr_q};
  assign tpr_d = tpr_we ? op_wdata[TPR_W-1:0] : tpr_q;

  // task priority, four bits held, upper bits read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tpr_q <= TPR_RST;
    end else begin
      tpr_q <= tpr_d;
    end
  end

  // one answer per request, one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q  <= 1'b0;
      gp_q    <= 1'b0;
      rdata_q <= 64'h0000_0000_0000_0000;
      mem_q   <= 5'h00;
      idt_q   <= 12'h000;
      push_q  <= 4'h0;
      pss_q   <= 1'b0;
      ssn_q   <= 1'b0;
      base_q  <= 4'h0;
      tss_q   <= 7'h00;
    end else begin
      done_q  <= op_valid;
      gp_q    <= op_valid && gp_any;
      rdata_q <= (op_valid && (op_code == OP_RD_TPR) && tpr_ok) ? rd_val : 64'h0;
      mem_q   <= op_valid ? mem_sz : 5'h00;
      idt_q   <= op_valid ? idt_off : 12'h000;
      push_q  <= op_valid ? push_sz : 4'h0;
      pss_q   <= op_valid && push_ss;
      ssn_q   <= op_valid && ss_null;
      base_q  <= op_valid ? base_sz : 4'h0;
      tss_q   <= op_valid ? tss_off : 7'h00;
    end
  end

  // -------------------------------------------------------------
  // mode status registers
  // -------------------------------------------------------------
  logic [2:0] lvl_q;
  logic       va64_q;
  logic       paef_q;
  logic [5:0] sbase_q;
  logic [5:0] slim_q;
  logic [5:0] sattr_q;
  logic [5:0] spfx_q;

  // status lags the mode inputs by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q   <= PAGE_LVL_LEG;
      va64_q  <= 1'b0;
      paef_q  <= 1'b0;
      sbase_q <= SEG_NONE;
      slim_q  <= SEG_NONE;
      sattr_q <= SEG_NONE;
      spfx_q  <= SEG_NONE;
    end else begin
      lvl_q   <= lm ? PAGE_LVL_LNG : PAGE_LVL_LEG;
      va64_q  <= m64;
      paef_q  <= lm && !pae_en;
      sbase_q <= m64 ? SEG_BASE64 : SEG_NONE;
      slim_q  <= m64 ? SEG_ALL : SEG_NONE;
      sattr_q <= m64 ? SEG_ATTR64 : SEG_NONE;
      spfx_q  <= m64 ? SEG_BASE64 : SEG_NONE;
    end
  end

  // -------------------------------------------------------------
  // interrupt priority gate
  // -------------------------------------------------------------
  lms_irq_if irq_bus ();

  assign irq_bus.task_priority_reg = tpr_q;
  assign irq_bus.req = ext_irq_req;
  assign irq_bus.cls = ext_irq_class;
  assign irq_bus.vec = ext_irq_vec;

  lms_irq_gate u_gate (
    .clk   (clk),
    .rst_n (rst_n),
    .gif   (irq_bus)
  );

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign op_done       = done_q;
  assign op_gp         = gp_q;
  assign op_rdata      = rdata_q;
  assign op_mem_bytes  = mem_q;
  assign op_idt_off    = idt_q;
  assign op_push_bytes = push_q;
  assign op_push_ss    = pss_q;
  assign op_ss_null    = ssn_q;
  assign op_base_bytes = base_q;
  assign op_tss_off    = tss_q;
  assign irq_deliver   = irq_bus.deliver;
  assign irq_vec       = irq_bus.dvec;
  assign irq_pending   = irq_bus.pending;
  assign tpr_value     = tpr_q;
  assign page_levels   = lvl_q;
  assign va64          = va64_q;
  assign pae_fault     = paef_q;
  assign seg_base_ign  = sbase_q;
  assign seg_lim_ign   = slim_q;
  assign seg_attr_ign  = sattr_q;
  assign seg_pfx_ign   = spfx_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_tpr_write;
    @(posedge clk) disable iff (!rst_n)
      op_valid && op_code == OP_WR_TPR && m64 && op_rex && !wr_bad
      |=> tpr_value == $past(op_wdata[3:0]) && !op_gp;
  endproperty
  a_tpr_write : assert property (p_tpr_write) else $error("priority not stored");

  property p_tpr_gate;
    @(posedge clk) disable iff (!rst_n)
      op_valid && is_tpr && !(m64 && op_rex)
      |=> op_gp && $stable(tpr_value) && op_rdata == 64'h0;
  endproperty
  a_tpr_gate : assert property (p_tpr_gate) else $error("priority reached outside 64-bit");

  property p_no_task_sw;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && op_code == OP_TASK_SW |=> op_gp && op_done;
  endproperty
  a_no_task_sw : assert property (p_no_task_sw) else $error("task switch allowed");

  property p_ltr_type;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && op_code == OP_LOAD_TR
      && (op_desc_type != TSS64_AVAIL || !code64) |=> op_gp;
  endproperty
  a_ltr_type : assert property (p_ltr_type) else $error("bad task segment load");

  property p_task_gate;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && op_code == OP_TASK_GT |=> op_gp;
  endproperty
  a_task_gate : assert property (p_task_gate) else $error("task gate not faulted");

  property p_tss_off;
    @(posedge clk) disable iff (!rst_n)
      op_valid && op_tss_sel == 4'h2 |=> op_tss_off == 7'h14;
  endproperty
  a_tss_off : assert property (p_tss_off) else $error("stack pointer offset wrong");

  property p_no_real;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && (op_code == OP_ENT_REAL || op_code == OP_ENT_V86)
      |=> op_gp;
  endproperty
  a_no_real : assert property (p_no_real) else $error("legacy mode entered");

  property p_paging;
    @(posedge clk) disable iff (!rst_n)
      long_active && !pae_en
      |=> pae_fault && va64 == $past(code64) && page_levels == 3'h4;
  endproperty
  a_paging : assert property (p_paging) else $error("paging status wrong");

  property p_seg_ign;
    @(posedge clk) disable iff (!rst_n)
      long_active && code64 |=> seg_lim_ign == 6'h3F && seg_attr_ign == 6'h39
      && seg_base_ign == 6'h0F;
  endproperty
  a_seg_ign : assert property (p_seg_ign) else $error("segment ignore wrong");

  property p_int_frame;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && op_code == OP_INT_ENT
      |=> op_push_bytes == 4'h8 && op_push_ss && op_mem_bytes == 5'h10
      && op_idt_off == {$past(op_vector), 4'h0};
  endproperty
  a_int_frame : assert property (p_int_frame) else $error("long interrupt frame wrong");

  property p_ss_null;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && op_pl_change && op_code == OP_CGATE32
      |=> op_ss_null && op_mem_bytes == 5'h10 && !op_gp;
  endproperty
  a_ss_null : assert property (p_ss_null) else $error("gate stack switch wrong");

  property p_cgate16;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && op_code == OP_CGATE16 |=> op_gp;
  endproperty
  a_cgate16 : assert property (p_cgate16) else $error("16-bit gate accepted");

  property p_psd;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && code64 && op_code == OP_LOAD_GDT
      |=> op_mem_bytes == 5'h0A && op_base_bytes == 4'h8;
  endproperty
  a_psd : assert property (p_psd) else $error("pseudo-descriptor size wrong");

  property p_sys_compat;
    @(posedge clk) disable iff (!rst_n)
      op_valid && long_active && !code64 && op_code == OP_LOAD_LDT
      |=> op_mem_bytes == 5'h08 && op_base_bytes == 4'h8;
  endproperty
  a_sys_compat : assert property (p_sys_compat) else $error("compat entry size wrong");

  c_int_long  : cover property (@(posedge clk) op_valid && long_active && is_int);
  c_tpr_write : cover property (@(posedge clk) tpr_we ##1 irq_deliver);
  c_gp_gate   : cover property (@(posedge clk) op_gp ##1 op_done);
  c_irq_held  : cover property (@(posedge clk) irq_pending && !irq_deliver ##1 irq_deliver);

endmodule : lms_core

/* tb/testbench.sv */
/*
  Self-checking bench for lms_core: priority register, task refusals,
  long-mode sizes, segment masks and the interrupt priority gate.
  Assumes the package, interface and design files are compiled first.
*/
`timescale 1ns/10ps
module testbench import lms_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk, rst_n, long_active, code64, pae_en, op_valid, op_rex, op_pl_change;
  logic        op_done, op_gp, op_push_ss, op_ss_null, irq_deliver, irq_pending;
  logic        va64, pae_fault, ext_irq_req;
  lms_op_type  op_code;
  logic [3:0]  op_desc_type, op_tss_sel, ext_irq_class, op_push_bytes, op_base_bytes;
  logic [3:0]  tpr_value, t;
  logic [7:0]  op_vector, ext_irq_vec, irq_vec, v;
  logic [63:0] op_wdata, op_rdata;
  logic [4:0]  op_mem_bytes;
  logic [11:0] op_idt_off;
  logic [6:0]  op_tss_off;
  logic [2:0]  page_levels;
  logic [5:0]  seg_base_ign, seg_lim_ign, seg_attr_ign, seg_pfx_ign;
  logic        l, c;
  int          n_fail, n_tests, i;
  lms_op_type  bad [5] = '{OP_TASK_SW, OP_TASK_GT, OP_CGATE16, OP_ENT_REAL, OP_ENT_V86};

  lms_core u_lms_core (.clk, .rst_n, .long_active, .code64, .pae_en, .op_valid, .op_code,
    .op_rex, .op_desc_type, .op_vector, .op_pl_change, .op_tss_sel, .op_wdata, .op_done,
    .op_gp, .op_rdata, .op_mem_bytes, .op_idt_off, .op_push_bytes, .op_push_ss,
    .op_ss_null, .op_base_bytes, .op_tss_off, .ext_irq_req, .ext_irq_class, .ext_irq_vec,
    .irq_deliver, .irq_vec, .irq_pending, .tpr_value, .page_levels, .va64, .pae_fault,
    .seg_base_ign, .seg_lim_ign, .seg_attr_ign, .seg_pfx_ign);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one request, answer checked at the following falling edge
  task automatic op(input lms_op_type cd, input logic [63:0] wd);
    @(negedge clk);
    op_valid = 1'b1;
    op_code  = cd;
    op_wdata = wd;
    @(negedge clk);
    op_valid = 1'b0;
    chk(op_done, 1);
  endtask : op

  task automatic setm(input logic lm, input logic cm, input logic pm);
    @(negedge clk);
    long_active = lm;
    code64      = cm;
    pae_en      = pm;
    @(negedge clk);
  endtask : setm

  function automatic logic [6:0] tss_exp(input logic [3:0] s);
    if (s < 4'h3) return 7'h04 + 7'(s) * 7'h08;
    if (s < 4'hA) return 7'h24 + 7'(s - 4'h3) * 7'h08;
    return 7'h66;
  endfunction : tss_exp

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is under two hundred cycles; this leaves wide margin
  initial begin
    #400000;
    n_fail++;
    summarize();
  end

  initial begin
    {rst_n, long_active, code64, pae_en, op_valid, op_rex, op_pl_change, ext_irq_req} = '0;
    op_code = OP_NONE;
    {op_desc_type, op_tss_sel, ext_irq_class, op_vector, ext_irq_vec} = '0;
    op_wdata = 64'h0;
    v = 8'($urandom(32'hE2A31B75));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    // legacy, compatibility, 64-bit, 64-bit without extension
    for (i = 0; i < 4; i++) begin
      l = (i != 0);
      c = (i > 1);
      setm(l, c, i != 3);
      chk(page_levels, l ? 3'h4 : 3'h2);
      chk({va64, pae_fault}, {l & c, i == 3});
      chk({seg_base_ign, seg_lim_ign}, (l & c) ? 12'h3FF : 12'h0);
      chk({seg_attr_ign, seg_pfx_ign}, (l & c) ? 12'hE4F : 12'h0);
    end
    $display("mode status done");
    setm(1'b1, 1'b1, 1'b1);
    op_rex = 1'b1;
    for (i = 0; i < 4; i++) begin
      t = (i == 0) ? 4'hF : 4'($urandom);
      op(OP_WR_TPR, {60'h0, t});
      chk({op_gp, tpr_value}, {1'b0, t});
      op(OP_RD_TPR, 64'h0);
      chk(op_rdata, {60'h0, t});
    end
    op(OP_WR_TPR, 64'h10);
    chk({op_gp, tpr_value}, {1'b1, t});
    op_rex = 1'b0;
    op(OP_WR_TPR, 64'h1);
    chk({op_gp, tpr_value}, {1'b1, t});
    op_rex = 1'b1;
    setm(1'b1, 1'b0, 1'b1);
    op(OP_RD_TPR, 64'h0);
    chk({op_gp, op_rdata}, {1'b1, 64'h0});
    $display("task priority done");
    // refusals in compatibility then 64-bit mode
    for (i = 0; i < 10; i++) begin
      if (i == 5) setm(1'b1, 1'b1, 1'b1);
      op(bad[i % 5], 64'h0);
      chk(op_gp, 1);
    end
    op_desc_type = TSS64_AVAIL;
    op(OP_LOAD_TR, 64'h0);
    chk({op_gp, op_mem_bytes, op_base_bytes}, {1'b0, 5'h10, 4'h8});
    op_desc_type = 4'h1;
    op(OP_LOAD_TR, 64'h0);
    chk(op_gp, 1);
    for (i = 0; i < 6; i++) begin
      c = (i < 3);
      if (i == 3) setm(1'b1, 1'b0, 1'b1);
      op(i % 3 == 0 ? OP_LOAD_GDT : (i % 3 == 1 ? OP_LOAD_IDT : OP_LOAD_LDT), 64'h0);
      chk(op_mem_bytes, i % 3 == 2 ? (c ? 5'h10 : 5'h08) : (c ? 5'h0A : 5'h06));
      chk(op_base_bytes, 4'h8);
    end
    op_desc_type = TSS64_AVAIL;
    op(OP_LOAD_TR, 64'h0);
    chk(op_gp, 1);
    $display("refusals and table loads done");
    // interrupt entry and call gate frames in long mode, then interrupt entry alone in legacy
    for (i = 0; i < 8; i++) begin
      l = (i < 4);
      if (i == 4) setm(1'b0, 1'b0, 1'b1);
      v = (i % 4 == 0) ? 8'hFF : 8'($urandom);
      op_vector    = v;
      op_pl_change = 1'($urandom);
      op(OP_INT_ENT, 64'h0);
      chk(op_idt_off, l ? {v, 4'h0} : {1'b0, v, 3'h0});
      chk(op_mem_bytes, l ? 5'h10 : 5'h08);
      chk(op_push_bytes, l ? 4'h8 : 4'h4);
      chk({op_push_ss, op_ss_null}, {l | op_pl_change, l & op_pl_change});
      if (l) begin
        op(OP_CGATE32, 64'h0);
        chk({op_gp, op_mem_bytes, op_push_bytes}, {1'b0, 5'h10, 4'h8});
        chk(op_ss_null, op_pl_change);
      end
    end
    for (i = 0; i < 16; i++) begin
      op_tss_sel = 4'(i);
      op(OP_INT_ENT, 64'h0);
      chk(op_tss_off, tss_exp(4'(i)));
    end
    $display("frames and state segment done");
    setm(1'b1, 1'b1, 1'b1);
    op(OP_WR_TPR, 64'h3);
    for (i = 0; i < 3; i++) begin
      v = 8'($urandom);
      ext_irq_req   = 1'b1;
      ext_irq_class = (i == 0) ? 4'h7 : (i == 1 ? 4'h3 : 4'h0);
      ext_irq_vec   = v;
      @(negedge clk);
      ext_irq_req = 1'b0;
      chk({irq_pending, irq_deliver}, {i < 2, i == 0});
      if (i < 2) chk(irq_vec, v);
      if (i == 1) begin
        repeat (3) @(negedge clk);
        chk({irq_pending, irq_deliver}, 2'b10);
        op(OP_WR_TPR, 64'h2);
        chk(irq_deliver, 1);
      end
      @(negedge clk);
      chk(irq_pending, 0);
    end
    $display("interrupt priority done");
    summarize();
  end
endmodule : testbench
